// ### rtl/pcsu_pkg.sv
// Package: register map, field positions and timing constants of the PHY control/status unit
package pcsu_pkg;
  localparam logic [4:0]  ADDR_BASIC_CTRL   = 5'h00;
  localparam logic [4:0]  ADDR_BASIC_STAT   = 5'h01;
  localparam logic [4:0]  ADDR_IRQ_STAT     = 5'h11;
  localparam logic [4:0]  ADDR_IRQ_CTRL     = 5'h12;
  localparam logic [4:0]  ADDR_TX100_CTRL   = 5'h13;
  localparam logic [4:0]  ADDR_SPECIAL_CTRL = 5'h14;
  localparam logic [4:0]  ADDR_LED_CFG      = 5'h1b;
  localparam int          BC_SW_RESET       = 15;
  localparam int          BC_POWERDOWN      = 11;
  localparam int          BS_REMOTE_FAULT   = 4;
  localparam int          BS_PRE_SUPP       = 6;
  localparam int          BS_LINK           = 2;
  localparam int          IC_OUT_EN         = 8;
  localparam int          IC_IRQ_EN         = 7;
  localparam int          IS_LINK_CHANGE    = 4;
  localparam int          IS_REMOTE_FAULT   = 1;
  localparam int          TX_ISOLATE        = 5;
  localparam int          TX_FEF_EN         = 6;
  localparam int          SC_PRE_SUPP       = 1;
  localparam int          LED_MODE_BIT      = 9;
  localparam logic [15:0] RST_BASIC_CTRL    = 16'h3000;
  localparam logic [15:0] RST_IRQ_CTRL      = 16'h0000;
  localparam logic [15:0] RST_TX100_CTRL    = 16'h00c0;
  localparam logic [15:0] RST_SPECIAL_CTRL  = 16'h0000;
  localparam logic [15:0] RST_LED_CFG       = 16'h0200;
  localparam int          PREAMBLE_BITS     = 32;
  localparam int          CLK_HZ            = 100_000_000;
  localparam int          LINK_BLINK_HZ     = 10;
  localparam int          ACT_BLINK_HZ      = 20;
  // Half period of each blink, rounded down
  localparam int          LINK_BLINK_CYC    = CLK_HZ / (2 * LINK_BLINK_HZ);
  localparam int          ACT_BLINK_CYC     = CLK_HZ / (2 * ACT_BLINK_HZ);
endpackage

// ### rtl/pcsu_sync.sv
// Three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pcsu_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pcsu_sync_s;
  pcsu_sync_s r;
  pcsu_sync_s next_r;
  always_comb begin
    next_r    = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // A bit changes only once second and third stage agree
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.q[i] = r.s3[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= {INIT, INIT, INIT, INIT};
    end else begin
      r <= next_r;
    end
  end
  assign dout = r.q;
endmodule
`default_nettype wire

// ### rtl/pcsu_top.sv
// PHY control/status unit: management slave, power-down/irq pin, LEDs, reset, fibre fault
// How it works
// - shared pin is power-down input until output-enable
// - power-down tri-states line, LEDs, isolates MII
// - management access keeps working in power-down
// - clear bit, hw or sw reset leaves power-down
// - pin held low forces power-down
// - output-enable stops sensing pin as power-down
// - sources reach pin only if enabled and masked
// - pin drops combinationally on pending enabled interrupt
// - status low byte shows all pending sources
// - LED mode bit selects LED meanings
// - link blinks 10 Hz, activity 20 Hz
// - software reset bit self-clears after resetting registers
// - resets restore defaults; straps sampled at hardware reset
// - status reports suppression; special bit selects it
// - first frame needs 32-bit preamble, idle between
// - local fault sets code-word bit until negotiation
// - transmit isolation ignores MII, suppresses link pulses
// - fibre mode bypasses scrambler, MLT3, equaliser
// - signal-detect pair selects fibre, never negotiation
// - fibre far-end fault on; partner fault forces fail
`timescale 1ns/1ps
`default_nettype none
module pcsu_top
  import pcsu_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic mdc,
  input  wire logic mdio_in,
  output var  logic mdio_out,
  output var  logic mdio_oe_n,
  input  wire logic powerdown_irq_pin_in,
  output var  logic powerdown_irq_pin_out,
  output var  logic powerdown_irq_pin_oe_n,
  input  wire logic signal_detect_pos,
  input  wire logic signal_detect_neg,
  input  wire logic [4:0] phy_addr_strap,
  input  wire logic an_en_strap,
  input  wire logic link_up,
  input  wire logic speed_100,
  input  wire logic full_duplex,
  input  wire logic activity,
  input  wire logic collision,
  input  wire logic rx_channel_fail,
  input  wire logic partner_fault_rx,
  input  wire logic local_fault,
  input  wire logic neg_complete,
  input  wire logic remote_fault_rx,
  output var  logic led_link,
  output var  logic led_speed,
  output var  logic led_act,
  output var  logic led_oe_n,
  output var  logic line_tx_oe_n,
  output var  logic mii_isolate,
  output var  logic link_pulse_suppress,
  output var  logic fibre_mode,
  output var  logic scramble_bypass,
  output var  logic tx_remote_fault_bit,
  output var  logic fef_tx,
  output var  logic link_fail_force
);
  typedef enum logic [3:0] {
    PCSU_IDLE = 4'b0001,
    PCSU_HDR  = 4'b0010,
    PCSU_DATA = 4'b0100,
    PCSU_WAIT = 4'b1000
  } pcsu_mstate_e;

  typedef struct packed {
    logic [15:0]  basic_ctrl;
    logic [15:0]  irq_control_reg;
    logic [7:0]   irq_pending;
    logic [15:0]  tx100_ctrl;
    logic [15:0]  special_ctrl;
    logic [15:0]  led_cfg;
    logic         rf_status;
    logic         link_prev;
    logic         rf_code;
    logic         strap_done;
    logic         an_strap;
    logic [4:0]   phy_addr;
    logic         mdc_prev;
    pcsu_mstate_e mstate;
    logic [5:0]   pre_cnt;
    logic         pre_seen;
    logic [5:0]   bit_cnt;
    logic [13:0]  hdr;
    logic [15:0]  shift;
    logic         mdio_out;
    logic         mdio_oe_n;
    logic [22:0]  link_tmr;
    logic         link_ph;
    logic [21:0]  act_tmr;
    logic         act_ph;
    logic         led_link;
    logic         led_speed;
    logic         led_act;
    logic         pd_out;
  } pcsu_s;

  pcsu_s r;
  pcsu_s next_r;
  logic [3:0] sync_q;
  logic       mdc_s;
  logic       mdio_s;
  logic       pin_s;
  logic       fibre_s;

  pcsu_sync #(.W(4), .INIT(4'b0110)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({mdc, mdio_in, powerdown_irq_pin_in, signal_detect_pos & ~signal_detect_neg}),
    .dout (sync_q)
  );
  assign {mdc_s, mdio_s, pin_s, fibre_s} = sync_q;

  function automatic logic [15:0] rd_reg(input pcsu_s s, input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      ADDR_BASIC_CTRL:   v = s.basic_ctrl;
      ADDR_BASIC_STAT: begin
        v[BS_PRE_SUPP]     = 1'b1;
        v[BS_REMOTE_FAULT] = s.rf_status;
        v[BS_LINK]         = link_up & ~(fibre_s & partner_fault_rx);
      end
      ADDR_IRQ_STAT:     v = {8'h00, s.irq_pending};
      ADDR_IRQ_CTRL:     v = s.irq_control_reg;
      ADDR_TX100_CTRL:   v = s.tx100_ctrl;
      ADDR_SPECIAL_CTRL: v = s.special_ctrl;
      ADDR_LED_CFG:      v = s.led_cfg;
      default:           v = 16'h0000;
    endcase
    return v;
  endfunction

  logic powered_down;
  logic irq_active;
  logic mdc_rise;
  logic mdc_fall;
  logic [15:0] bc_rst;
  logic [13:0] hdr_full;
  logic        rf_event;

  always_comb begin
    // pin sensing ends once the output is enabled
    powered_down = r.basic_ctrl[BC_POWERDOWN]
                 | (~r.irq_control_reg[IC_OUT_EN] & ~pin_s);
    irq_active   = r.irq_control_reg[IC_IRQ_EN]
                 & |(r.irq_pending & r.irq_control_reg[7:0]);
    mdc_rise     = mdc_s & ~r.mdc_prev;
    mdc_fall     = ~mdc_s & r.mdc_prev;
    bc_rst       = RST_BASIC_CTRL;
    bc_rst[12]   = r.an_strap;
    // Header as it stands once the current bit is shifted in
    hdr_full     = {r.hdr[12:0], mdio_s};
    rf_event     = remote_fault_rx | (fibre_s & r.tx100_ctrl[TX_FEF_EN] & partner_fault_rx);
  end

  always_comb begin
    next_r          = r;
    next_r.mdc_prev = mdc_s;
    // straps captured on the first clock after reset release
    if (!r.strap_done) begin
      next_r.strap_done     = 1'b1;
      next_r.phy_addr       = phy_addr_strap;
      next_r.an_strap       = an_en_strap;
      next_r.basic_ctrl[12] = an_en_strap;
    end
    // Interrupt sources: set wins over clear-on-read below
    if (link_up != r.link_prev) begin
      next_r.irq_pending[IS_LINK_CHANGE] = 1'b1;
    end
    next_r.link_prev = link_up;
    // local fault held in code word until negotiation succeeds
    if (local_fault) begin
      next_r.rf_code = 1'b1;
    end else if (neg_complete) begin
      next_r.rf_code = 1'b0;
    end
    if (rf_event) begin
      next_r.rf_status = 1'b1;
      next_r.irq_pending[IS_REMOTE_FAULT] = 1'b1;
    end
    // Management frame engine; runs in power-down too
    unique case (r.mstate)
      PCSU_IDLE: begin
        next_r.mdio_oe_n = 1'b1;
        if (mdc_rise) begin
          if (mdio_s) begin
            if (r.pre_cnt != 6'(PREAMBLE_BITS)) begin
              next_r.pre_cnt = r.pre_cnt + 6'h01;
            end
          end else if (r.pre_seen | r.pre_cnt == 6'(PREAMBLE_BITS)) begin
            if (r.pre_cnt != 6'h00 | r.pre_seen) begin
              next_r.mstate  = PCSU_HDR;
              next_r.bit_cnt = 6'h00;
              next_r.hdr     = 14'h0000;
            end
            if (r.pre_cnt == 6'(PREAMBLE_BITS) & r.special_ctrl[SC_PRE_SUPP]) begin
              next_r.pre_seen = 1'b1;
            end
            next_r.pre_cnt = 6'h00;
          end else begin
            next_r.pre_cnt = 6'h00;
          end
        end
      end
      PCSU_HDR: begin
        if (mdc_rise) begin
          next_r.hdr     = {r.hdr[12:0], mdio_s};
          next_r.bit_cnt = r.bit_cnt + 6'h01;
          // ST second bit, OP(2), PHYAD(5), REGAD(5), TA first bit
          if (r.bit_cnt == 6'd13) begin
            if (hdr_full[13] != 1'b1 | hdr_full[10:6] != r.phy_addr) begin
              next_r.mstate  = PCSU_WAIT;
              next_r.bit_cnt = 6'h00;
            end else begin
              next_r.mstate  = PCSU_DATA;
              next_r.bit_cnt = 6'h00;
              if (hdr_full[12:11] == 2'b10) begin
                next_r.shift = rd_reg(r, hdr_full[5:1]);
              end
            end
          end
        end
      end
      PCSU_DATA: begin
        if (r.hdr[13:12] == 2'b11) begin
          // Read: drive TA zero then data, changing after falling edges
          if (mdc_fall) begin
            next_r.mdio_oe_n = 1'b0;
            next_r.mdio_out  = r.bit_cnt == 6'h00 ? 1'b0 : r.shift[15];
            if (r.bit_cnt != 6'h00) begin
              next_r.shift = {r.shift[14:0], 1'b0};
            end
            next_r.bit_cnt = r.bit_cnt + 6'h01;
            if (r.bit_cnt == 6'd17) begin
              next_r.mdio_oe_n = 1'b1;
              next_r.mstate    = PCSU_IDLE;
            end
          end
        end else if (mdc_rise) begin
          next_r.bit_cnt = r.bit_cnt + 6'h01;
          if (r.bit_cnt != 6'h00) begin
            next_r.shift = {r.shift[14:0], mdio_s};
          end
          if (r.bit_cnt == 6'd16) begin
            next_r.mstate = PCSU_IDLE;
            unique case (r.hdr[5:1])
              ADDR_BASIC_CTRL: next_r.basic_ctrl = {r.shift[14:0], mdio_s};
              ADDR_IRQ_CTRL:   next_r.irq_control_reg = {r.shift[14:0], mdio_s};
              ADDR_TX100_CTRL: next_r.tx100_ctrl = {r.shift[14:0], mdio_s};
              ADDR_SPECIAL_CTRL: next_r.special_ctrl = {r.shift[14:0], mdio_s};
              ADDR_LED_CFG:    next_r.led_cfg = {r.shift[14:0], mdio_s};
              default: ;
            endcase
          end
        end
      end
      PCSU_WAIT: begin
        // A foreign frame ends only after a full run of preamble ones
        if (mdc_rise & ~mdio_s) begin
          next_r.bit_cnt = 6'h00;
        end else if (mdc_rise) begin
          next_r.bit_cnt = r.bit_cnt + 6'h01;
          if (r.bit_cnt == 6'(PREAMBLE_BITS - 1)) begin
            next_r.mstate  = PCSU_IDLE;
            next_r.pre_cnt = 6'(PREAMBLE_BITS);
          end
        end
      end
      default: next_r.mstate = PCSU_IDLE;
    endcase
    // Reading the status register clears what was shown
    if (r.mstate == PCSU_HDR & mdc_rise & r.bit_cnt == 6'd13 & hdr_full[12:11] == 2'b10
        & hdr_full[5:1] == ADDR_IRQ_STAT & hdr_full[10:6] == r.phy_addr & hdr_full[13]) begin
      next_r.irq_pending = 8'h00;
      if (link_up != r.link_prev) begin
        next_r.irq_pending[IS_LINK_CHANGE] = 1'b1;
      end
      if (rf_event) begin
        next_r.irq_pending[IS_REMOTE_FAULT] = 1'b1;
      end
    end
    if (r.mstate == PCSU_HDR & mdc_rise & r.bit_cnt == 6'd13 & hdr_full[12:11] == 2'b10
        & hdr_full[5:1] == ADDR_BASIC_STAT & hdr_full[10:6] == r.phy_addr & hdr_full[13]) begin
      next_r.rf_status = rf_event;
    end
    // software reset restores defaults and self-clears
    if (r.basic_ctrl[BC_SW_RESET]) begin
      next_r.basic_ctrl      = bc_rst;
      next_r.irq_control_reg = RST_IRQ_CTRL;
      next_r.irq_pending     = 8'h00;
      next_r.tx100_ctrl      = RST_TX100_CTRL;
      next_r.special_ctrl    = RST_SPECIAL_CTRL;
      next_r.led_cfg         = RST_LED_CFG;
      next_r.rf_status       = 1'b0;
      next_r.rf_code         = 1'b0;
    end
    if (r.link_tmr == 23'(LINK_BLINK_CYC - 1)) begin
      next_r.link_tmr = 23'h000000;
      next_r.link_ph  = ~r.link_ph;
    end else begin
      next_r.link_tmr = r.link_tmr + 23'h000001;
    end
    if (r.act_tmr == 22'(ACT_BLINK_CYC - 1)) begin
      next_r.act_tmr = 22'h000000;
      next_r.act_ph  = ~r.act_ph;
    end else begin
      next_r.act_tmr = r.act_tmr + 22'h000001;
    end
    next_r.led_speed = speed_100;
    if (r.led_cfg[LED_MODE_BIT]) begin
      next_r.led_link = link_up & ~(activity & r.link_ph);
      if (collision) begin
        next_r.led_act = r.act_ph;
      end else begin
        next_r.led_act = full_duplex & link_up;
      end
    end else begin
      next_r.led_link = link_up;
      next_r.led_act  = activity & (full_duplex | r.act_ph);
    end
    next_r.pd_out = powered_down;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '{basic_ctrl: RST_BASIC_CTRL, irq_control_reg: RST_IRQ_CTRL, tx100_ctrl: RST_TX100_CTRL,
             special_ctrl: RST_SPECIAL_CTRL, led_cfg: RST_LED_CFG, mstate: PCSU_IDLE,
             mdio_oe_n: 1'b1, mdc_prev: 1'b0, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign mdio_out               = r.mdio_out;
  assign mdio_oe_n              = r.mdio_oe_n;
  // pin follows pending interrupt with no clock in the path
  assign powerdown_irq_pin_out  = ~irq_active;
  assign powerdown_irq_pin_oe_n = ~r.irq_control_reg[IC_OUT_EN];
  assign led_link               = r.led_link;
  assign led_speed              = r.led_speed;
  assign led_act                = r.led_act;
  assign led_oe_n               = r.pd_out;
  assign line_tx_oe_n           = r.pd_out | r.tx100_ctrl[TX_ISOLATE];
  assign mii_isolate            = r.pd_out | r.tx100_ctrl[TX_ISOLATE];
  assign link_pulse_suppress    = r.tx100_ctrl[TX_ISOLATE];
  assign fibre_mode             = fibre_s;
  assign scramble_bypass        = fibre_s;
  assign tx_remote_fault_bit    = r.rf_code;
  assign fef_tx                 = fibre_s & r.tx100_ctrl[TX_FEF_EN] & rx_channel_fail;
  assign link_fail_force        = fibre_s & r.tx100_ctrl[TX_FEF_EN] & partner_fault_rx;
endmodule
`default_nettype wire

// ### test/pcsu_asserts.sv
// Checker: port-level properties of the PHY control/status unit
`timescale 1ns/1ps
`default_nettype none
module pcsu_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic powerdown_irq_pin_in,
  input wire logic powerdown_irq_pin_out,
  input wire logic powerdown_irq_pin_oe_n,
  input wire logic signal_detect_pos,
  input wire logic signal_detect_neg,
  input wire logic neg_complete,
  input wire logic led_oe_n,
  input wire logic line_tx_oe_n,
  input wire logic mii_isolate,
  input wire logic link_pulse_suppress,
  input wire logic fibre_mode,
  input wire logic scramble_bypass,
  input wire logic tx_remote_fault_bit,
  input wire logic fef_tx,
  input wire logic link_fail_force
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rst_oe; $rose(nrst) |-> powerdown_irq_pin_oe_n; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("pin not an input after reset");
  property p_rst_irq; $rose(nrst) |-> powerdown_irq_pin_out; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq active after reset");
  property p_pd_iso; led_oe_n && $past(led_oe_n) |-> line_tx_oe_n && mii_isolate; endproperty
  a_pd_iso: assert property (p_pd_iso) else $error("power-down without isolation");
  property p_pin_pd; (powerdown_irq_pin_oe_n && !powerdown_irq_pin_in) [*8] |=> led_oe_n; endproperty
  a_pin_pd: assert property (p_pin_pd) else $error("low pin gave no power-down");
  property p_txiso;
    link_pulse_suppress && $past(link_pulse_suppress) |-> mii_isolate && line_tx_oe_n;
  endproperty
  a_txiso: assert property (p_txiso) else $error("isolation incomplete");
  property p_fib; fibre_mode && $past(fibre_mode) |-> scramble_bypass; endproperty
  a_fib: assert property (p_fib) else $error("fibre without bypass");
  property p_sd_tp; (!signal_detect_pos && !signal_detect_neg) [*8] |=> !fibre_mode; endproperty
  a_sd_tp: assert property (p_sd_tp) else $error("fibre with detect low");
  property p_fef; fef_tx || link_fail_force |-> fibre_mode; endproperty
  a_fef: assert property (p_fef) else $error("fault logic outside fibre");
  property p_rfb; tx_remote_fault_bit && !neg_complete |=> tx_remote_fault_bit; endproperty
  a_rfb: assert property (p_rfb) else $error("fault bit dropped early");
endmodule
bind pcsu_top pcsu_asserts u_pcsu_asserts (.*);
`default_nettype wire

// ### test/pcsu_sta.sv
// Station management model: drives the management clock and data line
`timescale 1ns/1ps
`default_nettype none
module pcsu_sta (
  output var  logic mdc,
  output var  logic sta_oe,
  output var  logic sta_d,
  input  wire logic mdio_line
);
  logic [15:0] rdata;
  logic        smp;
  event        done;
  initial begin
    mdc = 1'b0;
    sta_oe = 1'b0;
    sta_d = 1'b1;
    // One clock pulse (rise then fall) while the block is still held in reset
    #20 mdc = 1'b1;
    #20 mdc = 1'b0;
  end
  // One 125 ns bit time; the clock rests low between frames
  task automatic bit_t(input logic oe, input logic d);
    sta_oe = oe;
    sta_d = d;
    #62.5 mdc = 1'b1;
    smp = mdio_line;
    #62.5 mdc = 1'b0;
  endtask
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, input int pre);
    logic [13:0] hdr;
    hdr = {2'b01, rd, !rd, pa, ra};
    for (int i = 0; i < pre; i++) bit_t(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) bit_t(1'b1, hdr[i]);
    bit_t(!rd, 1'b1);
    bit_t(!rd, 1'b0);
    for (int i = 15; i >= 0; i--) begin
      bit_t(!rd, wd[i]);
      rdata = {rdata[14:0], smp};
    end
    bit_t(1'b0, 1'b1);
    if (rd) -> done;
  endtask
endmodule
`default_nettype wire

// ### test/pcsu_tb_top.sv
// Testbench: drives the PHY control/status unit through pins and management frames
`timescale 1ns/1ps
`default_nettype none
module pcsu_tb_top;
  import pcsu_pkg::*;
  logic        clk, nrst, mdc, mdio_in, mdio_out, mdio_oe_n, sta_oe, sta_d, pd_ext;
  logic        powerdown_irq_pin_in, powerdown_irq_pin_out, powerdown_irq_pin_oe_n;
  logic        signal_detect_pos, signal_detect_neg, an_en_strap, link_up, speed_100;
  logic        full_duplex, activity, collision, rx_channel_fail, partner_fault_rx;
  logic        local_fault, neg_complete, remote_fault_rx, led_link, led_speed, led_act;
  logic        led_oe_n, line_tx_oe_n, mii_isolate, link_pulse_suppress, fibre_mode;
  logic        scramble_bypass, tx_remote_fault_bit, fef_tx, link_fail_force;
  logic [4:0]  phy_addr_strap;
  logic [15:0] exp_q[$];
  int          err_total, checked, seed;
  // Released management line floats to its pull-up; the undriven pin reads pd_ext
  assign mdio_in = !mdio_oe_n ? mdio_out : (sta_oe ? sta_d : 1'b1);
  assign powerdown_irq_pin_in = !powerdown_irq_pin_oe_n ? powerdown_irq_pin_out : pd_ext;
  pcsu_top u_pcsu_top (.*);
  pcsu_sta u_pcsu_sta (.mdc(mdc), .sta_oe(sta_oe), .sta_d(sta_d), .mdio_line(mdio_in));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    u_pcsu_sta.frame(1'b0, phy_addr_strap, ra, d, 32);
    w(20);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] e, input int pre = 32);
    exp_q.push_back(e);
    u_pcsu_sta.frame(1'b1, phy_addr_strap, ra, 16'h0000, pre);
    w(20);
  endtask
  always @(u_pcsu_sta.done) check(u_pcsu_sta.rdata, exp_q.pop_front());
  initial begin
    #500000;
    err_total++;
    $display("Error %0t: run timed out", $time);
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 57276;
    err_total = 0;
    checked = 0;
    clk = 1'b0;
    nrst = 1'b0;
    pd_ext = 1'b1;
    an_en_strap = 1'b1;
    {signal_detect_pos, signal_detect_neg, link_up, speed_100, full_duplex} = '0;
    {activity, collision, rx_channel_fail, partner_fault_rx} = '0;
    {local_fault, neg_complete, remote_fault_rx} = '0;
    phy_addr_strap = 5'($random(seed));
    w(10);
    nrst = 1'b1;
    w(8);
    check(powerdown_irq_pin_oe_n, 1'b1);
    check(powerdown_irq_pin_out, 1'b1);
    rd(ADDR_IRQ_CTRL, RST_IRQ_CTRL);
    rd(ADDR_LED_CFG, RST_LED_CFG);
    $display("test reset defaults done");
    pd_ext = 1'b0;
    w(12);
    check({led_oe_n, line_tx_oe_n, mii_isolate}, 3'b111);
    wr(ADDR_SPECIAL_CTRL, 16'h0002);
    rd(ADDR_SPECIAL_CTRL, 16'h0002);
    rd(ADDR_SPECIAL_CTRL, 16'h0002, 0);
    wr(ADDR_IRQ_CTRL, 16'h0180);
    check(powerdown_irq_pin_oe_n, 1'b0);
    check(led_oe_n, 1'b0);
    pd_ext = 1'b1;
    $display("test pin power-down done");
    wr(ADDR_IRQ_CTRL, 16'h0190);
    link_up = 1'b1;
    w(10);
    check(powerdown_irq_pin_out, 1'b0);
    rd(ADDR_IRQ_STAT, 16'h0010);
    check(powerdown_irq_pin_out, 1'b1);
    wr(ADDR_IRQ_CTRL, 16'h0180);
    link_up = 1'b0;
    w(10);
    check(powerdown_irq_pin_out, 1'b1);
    $display("test interrupt done");
    {link_up, speed_100, full_duplex} = 3'b111;
    w(10);
    check({led_link, led_speed, led_act}, 3'b111);
    wr(ADDR_LED_CFG, 16'h0000);
    check({led_link, led_act}, 2'b10);
    $display("test leds done");
    wr(ADDR_BASIC_CTRL, 16'h3800);
    check(led_oe_n, 1'b1);
    rd(ADDR_BASIC_CTRL, 16'h3800);
    wr(ADDR_BASIC_CTRL, 16'h3000);
    check(led_oe_n, 1'b0);
    wr(ADDR_BASIC_CTRL, 16'h3800);
    wr(ADDR_BASIC_CTRL, 16'h8800);
    check(led_oe_n, 1'b0);
    rd(ADDR_BASIC_CTRL, RST_BASIC_CTRL);
    rd(ADDR_LED_CFG, RST_LED_CFG);
    check(powerdown_irq_pin_oe_n, 1'b1);
    $display("test resets done");
    wr(ADDR_TX100_CTRL, 16'h00a0);
    check({link_pulse_suppress, mii_isolate, line_tx_oe_n}, 3'b111);
    wr(ADDR_TX100_CTRL, RST_TX100_CTRL);
    check(mii_isolate, 1'b0);
    $display("test isolation done");
    signal_detect_pos = 1'b1;
    w(10);
    check({fibre_mode, scramble_bypass}, 2'b11);
    rx_channel_fail = 1'b1;
    partner_fault_rx = 1'b1;
    w(4);
    check({fef_tx, link_fail_force}, 2'b11);
    signal_detect_pos = 1'b0;
    w(10);
    check({fibre_mode, fef_tx}, 2'b00);
    {rx_channel_fail, partner_fault_rx} = 2'b00;
    rd(ADDR_BASIC_STAT, 16'h0054);
    rd(ADDR_IRQ_STAT, 16'h0002);
    $display("test fibre done");
    local_fault = 1'b1;
    w(1);
    local_fault = 1'b0;
    w(6);
    check(tx_remote_fault_bit, 1'b1);
    neg_complete = 1'b1;
    w(10);
    check(tx_remote_fault_bit, 1'b0);
    neg_complete = 1'b0;
    $display("test remote fault done");
    an_en_strap = 1'b0;
    wr(ADDR_BASIC_CTRL, 16'h3800);
    nrst = 1'b0;
    w(10);
    nrst = 1'b1;
    w(8);
    check(led_oe_n, 1'b0);
    rd(ADDR_BASIC_CTRL, RST_BASIC_CTRL & 16'hefff);
    $display("test hardware reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
